// ==== rtl/pwmch_consts.svh ====
`ifndef PWMCH_CONSTS_SVH
`define PWMCH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PWMCH_OFS_CTRL 5'h00
`define PWMCH_OFS_PERIOD 5'h04
`define PWMCH_OFS_DUTY 5'h08
`define PWMCH_OFS_FORCE 5'h0C
`define PWMCH_OFS_STATUS 5'h10
`define PWMCH_OFS_COUNT 5'h14

// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define PWMCH_CTRL_EN 0
`define PWMCH_CTRL_FREEZE 1
`define PWMCH_CTRL_MODE_LO 2
`define PWMCH_CTRL_MODE_HI 3
`define PWMCH_CTRL_UDM_LO 4
`define PWMCH_CTRL_UDM_HI 5
`define PWMCH_CTRL_ROT 6
`define PWMCH_CTRL_EXTSEL 7
`define PWMCH_CTRL_SL 8
`define PWMCH_CTRL_FUS_LO 9
`define PWMCH_CTRL_FUS_HI 10
`define PWMCH_CTRL_CRS_LO 11
`define PWMCH_CTRL_CRS_HI 12
`define PWMCH_CTRL_W 13
`define PWMCH_FORCE_GO 0

// ----------------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------------
`define PWMCH_MODE_PWM 2'h2
`define PWMCH_SEL_RESET 2'h2
`define PWMCH_UDM_UP 2'h0
`define PWMCH_RST_CTRL 13'h0008
`define PWMCH_RST_PERIOD 16'h00FF
`define PWMCH_RST_DUTY 16'h0080
`define PWMCH_ACK_CYCLES 1

`endif

// ==== rtl/pwmch_pkg.sv ====
package pwmch_pkg;
   // Counting direction of the main counter
   typedef enum logic [0:0] {
      PWMCH_DIR_UP = 1'b0,
      PWMCH_DIR_DOWN = 1'b1
   } pwmch_dir_t;

   typedef logic [1:0] pwmch_sel_t;
   typedef logic [31:0] pwmch_word_t;
endpackage : pwmch_pkg

// ==== rtl/pwmch_cfg_if.sv ====
`timescale 1ns/100ps
// Configuration from the register file to the channel core, status back
interface pwmch_cfg_if #(parameter int CW = 16);
   logic enable;
   logic freeze;
   logic [1:0] mode;
   logic [1:0] count_direction_mode;
   logic reset_on_trigger;
   logic ext_sel;
   logic signal_level;
   logic [1:0] force_update_select;
   logic [1:0] counter_reset_select;
   logic [CW-1:0] period_compare;
   logic [CW-1:0] duty_compare;
   logic force_pulse;
   logic [CW-1:0] main_counter;
   logic out_level;
   logic alt_level;
   logic dir_down;
   logic active_level;

   modport regs (
      output enable, freeze, mode, count_direction_mode, reset_on_trigger, ext_sel,
      output signal_level, force_update_select, counter_reset_select,
      output period_compare, duty_compare, force_pulse,
      input main_counter, out_level, alt_level, dir_down, active_level
   );
   modport core (
      input enable, freeze, mode, count_direction_mode, reset_on_trigger, ext_sel,
      input signal_level, force_update_select, counter_reset_select,
      input period_compare, duty_compare, force_pulse,
      output main_counter, out_level, alt_level, dir_down, active_level
   );
endinterface : pwmch_cfg_if

// ==== rtl/pwmch_regs.sv ====
`timescale 1ns/100ps
`include "pwmch_consts.svh"
module pwmch_regs #(
   parameter int CW = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   pwmch_cfg_if.regs cfg
);
   import pwmch_pkg::*;

   logic ack_q;
   logic wr_go;
   logic [`PWMCH_CTRL_W-1:0] ctrl_q;
   logic [CW-1:0] period_q;
   logic [CW-1:0] duty_q;
   logic force_q;
   pwmch_word_t rd_d;
   pwmch_word_t rdata_q;

   // ------------------------------------------------------------------------
   // Byte lane merge
   // ------------------------------------------------------------------------
   function automatic pwmch_word_t merge(input pwmch_word_t old, input pwmch_word_t nw,
                                         input logic [3:0] be);
      pwmch_word_t r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ------------------------------------------------------------------------
   // Avalon handshake
   // ------------------------------------------------------------------------
   // One wait cycle: read data is looked up at the first edge, shown at the second
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_go = avs_write & ack_q;

   // Writes land only at the edge where waitrequest is low
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `PWMCH_RST_CTRL;
         period_q <= `PWMCH_RST_PERIOD;
         duty_q <= `PWMCH_RST_DUTY;
      end else if (wr_go) begin
         case (avs_address)
            `PWMCH_OFS_CTRL: ctrl_q <= `PWMCH_CTRL_W'(merge(32'(ctrl_q), avs_writedata,
                                                            avs_byteenable));
            `PWMCH_OFS_PERIOD: period_q <= CW'(merge(32'(period_q), avs_writedata,
                                                     avs_byteenable));
            `PWMCH_OFS_DUTY: duty_q <= CW'(merge(32'(duty_q), avs_writedata,
                                                 avs_byteenable));
            default: ;
         endcase
      end
   end

   // Force update strobe, one cycle long, never stored
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         force_q <= 1'b0;
      end else begin
         force_q <= wr_go && (avs_address == `PWMCH_OFS_FORCE) && avs_byteenable[0] &&
                    avs_writedata[`PWMCH_FORCE_GO];
      end
   end

   // Read mux; unmapped words read zero
   always_comb begin
      rd_d = 32'h0000_0000;
      case (avs_address)
         `PWMCH_OFS_CTRL: rd_d = 32'(ctrl_q);
         `PWMCH_OFS_PERIOD: rd_d = 32'(period_q);
         `PWMCH_OFS_DUTY: rd_d = 32'(duty_q);
         `PWMCH_OFS_STATUS: rd_d = {28'h0000000, cfg.active_level, cfg.dir_down,
                                    cfg.alt_level, cfg.out_level};
         `PWMCH_OFS_COUNT: rd_d = 32'(cfg.main_counter);
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read & ~ack_q) begin
         rdata_q <= rd_d;
      end
   end
   assign avs_readdata = rdata_q;

   // ------------------------------------------------------------------------
   // Fields to the core
   // ------------------------------------------------------------------------
   assign cfg.enable = ctrl_q[`PWMCH_CTRL_EN];
   assign cfg.freeze = ctrl_q[`PWMCH_CTRL_FREEZE];
   assign cfg.mode = ctrl_q[`PWMCH_CTRL_MODE_HI:`PWMCH_CTRL_MODE_LO];
   assign cfg.count_direction_mode = ctrl_q[`PWMCH_CTRL_UDM_HI:`PWMCH_CTRL_UDM_LO];
   assign cfg.reset_on_trigger = ctrl_q[`PWMCH_CTRL_ROT];
   assign cfg.ext_sel = ctrl_q[`PWMCH_CTRL_EXTSEL];
   assign cfg.signal_level = ctrl_q[`PWMCH_CTRL_SL];
   assign cfg.force_update_select = ctrl_q[`PWMCH_CTRL_FUS_HI:`PWMCH_CTRL_FUS_LO];
   assign cfg.counter_reset_select = ctrl_q[`PWMCH_CTRL_CRS_HI:`PWMCH_CTRL_CRS_LO];
   assign cfg.period_compare = period_q;
   assign cfg.duty_compare = duty_q;
   assign cfg.force_pulse = force_q;
endmodule : pwmch_regs

// ==== rtl/pwmch_top.sv ====
`timescale 1ns/100ps
`include "pwmch_consts.svh"
module pwmch_top #(
   parameter int CW = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic prev_trigger,
   input wire logic external_capture_trigger,
   output logic compare_unit_trigger,
   output logic channel_output,
   output logic channel_output_alt
);
   import pwmch_pkg::*;

   pwmch_cfg_if #(.CW(CW)) cfg ();

   // ------------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------------
   pwmch_regs #(.CW(CW)) u_regs (
      .mclk(mclk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .cfg(cfg)
   );

   // ------------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------------
   // Both update selects share the same reset encoding
   function automatic logic sel_is_reset(input pwmch_sel_t s);
      return s == `PWMCH_SEL_RESET;
   endfunction : sel_is_reset

   logic pwm_mode;
   logic updown;
   logic run;
   logic frozen;
   logic trig_src;
   logic dir_reset;
   logic force_rst;
   logic period_hit;
   logic duty_hit;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   pwmch_dir_t dir_q;
   pwmch_dir_t dir_d;
   logic lvl_q;
   logic lvl_now;
   logic out_q;
   logic out_d;
   logic alt_q;
   logic trig_q;

   // ------------------------------------------------------------------------
   // Mode qualification
   // ------------------------------------------------------------------------
   assign pwm_mode = cfg.mode == `PWMCH_MODE_PWM;
   assign updown = cfg.count_direction_mode != `PWMCH_UDM_UP;
   assign run = pwm_mode & cfg.enable;
   // Disabled with freeze set: outputs and level stand still; a force update still clears the counter
   assign frozen = pwm_mode & ~cfg.enable & cfg.freeze;
   // Neighbour trigger and capture trigger come from this same clock
   assign trig_src = cfg.ext_sel ? external_capture_trigger : prev_trigger;
   assign dir_reset = run & updown & cfg.reset_on_trigger & trig_src;
   assign force_rst = pwm_mode & cfg.force_pulse &
                      sel_is_reset(cfg.force_update_select) &
                      sel_is_reset(cfg.counter_reset_select);
   assign period_hit = run & (cnt_q == cfg.period_compare);
   assign duty_hit = run & (cnt_q == cfg.duty_compare);

   // ------------------------------------------------------------------------
   // Main counter and direction
   // ------------------------------------------------------------------------
   // Up-down turns at the period value and at zero; a trigger forces up below the period value
   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (force_rst) begin
         cnt_d = '0;
         dir_d = PWMCH_DIR_UP;
      end else if (run && !updown) begin
         dir_d = PWMCH_DIR_UP;
         if (cnt_q >= cfg.period_compare) begin
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end else if (run) begin
         if (dir_reset) begin
            dir_d = PWMCH_DIR_UP;
         end
         if ((dir_reset || dir_q == PWMCH_DIR_UP) && cnt_q >= cfg.period_compare) begin
            dir_d = PWMCH_DIR_DOWN;
            cnt_d = (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
         end else if (dir_reset || dir_q == PWMCH_DIR_UP) begin
            cnt_d = cnt_q + 1'b1;
         end else if (cnt_q == '0) begin
            dir_d = PWMCH_DIR_UP;
            cnt_d = (cfg.period_compare == '0) ? cnt_q : cnt_q + 1'b1;
         end else begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dir_q <= PWMCH_DIR_UP;
      end else begin
         dir_q <= dir_d;
      end
   end

   // ------------------------------------------------------------------------
   // Active signal level
   // ------------------------------------------------------------------------
   // Up counting holds a written level back until a compare trigger or force update, so a
   // period never shows a half-applied level; up-down takes it at once
   assign lvl_now = (updown || period_hit || duty_hit || force_rst) ?
                    cfg.signal_level : lvl_q;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lvl_q <= 1'b0;
      end else if (!frozen) begin
         lvl_q <= lvl_now;
      end
   end

   // ------------------------------------------------------------------------
   // Output levels
   // ------------------------------------------------------------------------
   // Force reset, and the period start when counting up, beat a duty match in the same cycle
   always_comb begin
      out_d = out_q;
      if (frozen) begin
         out_d = out_q;
      end else if (force_rst) begin
         out_d = cfg.signal_level;
      end else if (!run) begin
         out_d = ~cfg.signal_level;
      end else if (!updown && period_hit) begin
         out_d = lvl_now;
      end else if (duty_hit && (updown ? (dir_q == PWMCH_DIR_UP) : 1'b1)) begin
         out_d = ~lvl_now;
      end else if (duty_hit) begin
         out_d = lvl_now;
      end else if (updown && cnt_q == '0) begin
         out_d = lvl_now;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_q <= 1'b0;
      end else begin
         out_q <= out_d;
      end
   end

   // Complement output; it must also hold when frozen, not fall to a level
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         alt_q <= 1'b1;
      end else if (!frozen) begin
         alt_q <= ~out_d;
      end
   end

   // Period match pulse for the following channel
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= period_hit;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs and status
   // ------------------------------------------------------------------------
   assign channel_output = out_q;
   assign channel_output_alt = alt_q;
   assign compare_unit_trigger = trig_q;
   assign cfg.main_counter = cnt_q;
   assign cfg.out_level = out_q;
   assign cfg.alt_level = alt_q;
   assign cfg.dir_down = dir_q == PWMCH_DIR_DOWN;
   assign cfg.active_level = lvl_q;
endmodule : pwmch_top

// ==== sim/pwmch_assertions.sv ====
`timescale 1ns/100ps
`include "pwmch_consts.svh"
// ----
// Port checker, control shadowed from bus writes
// ----
module pwmch_assertions #(
   parameter int CW = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic prev_trigger,
   input wire logic external_capture_trigger,
   input wire logic compare_unit_trigger,
   input wire logic channel_output,
   input wire logic channel_output_alt
);
   logic [12:0] ctl_q;
   logic [CW-1:0] duty_q;
   logic [CW-1:0] pos_q;
   logic clean_q;
   wire wdone = avs_write && !avs_waitrequest;
   wire [CW-1:0] pos = compare_unit_trigger ? '0 : pos_q;
   wire pwm = ctl_q[3:2] == `PWMCH_MODE_PWM;
   wire up_run = ctl_q[0] && pwm && ctl_q[5:4] == `PWMCH_UDM_UP;
   wire frz = !ctl_q[0] && ctl_q[1] && pwm;
   wire halt = !ctl_q[0] || !pwm;
   wire fsel = ctl_q[10:9] == `PWMCH_SEL_RESET && ctl_q[12:11] == `PWMCH_SEL_RESET;
   wire fgo = wdone && avs_address == `PWMCH_OFS_FORCE && avs_writedata[0];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // Shadow copies; partial-lane writes to these are not tracked
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl_q <= `PWMCH_RST_CTRL;
         duty_q <= `PWMCH_RST_DUTY;
      end else if (wdone && avs_address == `PWMCH_OFS_CTRL) begin
         ctl_q <= avs_writedata[12:0];
      end else if (wdone && avs_address == `PWMCH_OFS_DUTY) begin
         duty_q <= avs_writedata[CW-1:0];
      end
   end

   // Position in period; any write spoils it until the next wrap
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pos_q <= '0;
         clean_q <= 1'b0;
      end else begin
         pos_q <= pos + 1'b1;
         clean_q <= !wdone && (clean_q || compare_unit_trigger);
      end
   end

   a_alt_inverse: assert property (channel_output_alt == !channel_output)
      else $error("alternate output is not the complement");
   a_frozen_hold: assert property (frz && $past(frz) |-> $stable(channel_output))
      else $error("frozen output moved");
   a_duty_edge: assert property (up_run && clean_q && !compare_unit_trigger |->
      channel_output == (pos <= duty_q ? ctl_q[8] : !ctl_q[8]))
      else $error("output level wrong for position in period");
   a_force_level: assert property (fgo && fsel && up_run |-> ##2 channel_output == ctl_q[8])
      else $error("force update did not restart at signal level");
   a_halt_quiet: assert property (halt && $past(halt) |-> !compare_unit_trigger)
      else $error("trigger while channel idle");
   a_trig_single: assert property (compare_unit_trigger |=> !compare_unit_trigger)
      else $error("trigger longer than one cycle");
   a_one_wait: assert property (avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait state");
   a_wait_first: assert property ((avs_read || avs_write) && !avs_waitrequest |->
      $past(avs_waitrequest))
      else $error("access completed without a wait state");

   c_force: cover property (fgo && fsel);
   c_frozen: cover property (frz && ctl_q[6]);
   c_ext_trig: cover property (external_capture_trigger && ctl_q[7] && ctl_q[6]);
endmodule : pwmch_assertions

bind pwmch_top pwmch_assertions #(.CW(CW)) u_pwmch_assertions (
   .mclk(mclk),
   .rst(rst),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .prev_trigger(prev_trigger),
   .external_capture_trigger(external_capture_trigger),
   .compare_unit_trigger(compare_unit_trigger),
   .channel_output(channel_output),
   .channel_output_alt(channel_output_alt)
);

// ==== sim/pwm_timer_channel_output_bench.sv ====
`timescale 1ns/100ps
module pwm_timer_channel_output_bench;
   typedef struct {logic wr; logic [4:0] adr; logic [3:0] be; logic [31:0] d;} pwmch_row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic prev_trigger = 1'b0;
   logic external_capture_trigger = 1'b0;
   logic compare_unit_trigger;
   logic channel_output;
   logic channel_output_alt;
   logic [31:0] rd;
   logic held;
   logic [31:0] cnt_seen;
   int fails = 0;
   int n_compared = 0;
   // Reads compare d; writes drive it
   pwmch_row_t rows [12] = '{
      '{0, 5'h00, 4'hF, 32'h8}, '{0, 5'h04, 4'hF, 32'hFF}, '{0, 5'h08, 4'hF, 32'h80},
      '{0, 5'h0C, 4'hF, 32'h0}, '{0, 5'h14, 4'hF, 32'h0}, '{1, 5'h04, 4'hF, 32'hFFFF1234},
      '{1, 5'h04, 4'h1, 32'hAB}, '{0, 5'h04, 4'hF, 32'h12AB}, '{1, 5'h18, 4'hF, 32'h55},
      '{0, 5'h18, 4'hF, 32'h0}, '{0, 5'h01, 4'hF, 32'h0}, '{0, 5'h00, 4'hF, 32'h8}};

   initial forever #2.5 mclk = ~mclk;

   pwmch_top #(.CW(16)) u_pwmch_top (
      .mclk(mclk),
      .rst(rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .prev_trigger(prev_trigger),
      .external_capture_trigger(external_capture_trigger),
      .compare_unit_trigger(compare_unit_trigger),
      .channel_output(channel_output),
      .channel_output_alt(channel_output_alt)
   );

   // ----
   // Helpers
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Waitrequest and read data taken at the rising edge, before its own updates land
   task automatic bus(input logic wr, input logic [4:0] a, input logic [3:0] be,
                      input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_byteenable <= be;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wait_trig();
      do @(negedge mclk); while (compare_unit_trigger !== 1'b1);
   endtask : wait_trig

   task automatic pulse(input logic p, input logic e);
      @(posedge mclk);
      prev_trigger <= p;
      external_capture_trigger <= e;
      @(posedge mclk);
      prev_trigger <= 1'b0;
      external_capture_trigger <= 1'b0;
   endtask : pulse

   task automatic end_sim();
      if (fails == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   // Run takes about a thousand cycles; cut off well beyond
   initial begin
      #100000;
      fails++;
      end_sim();
   end

   // ----
   // Main sequence
   // ----
   initial begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].adr, rows[i].be, rows[i].d);
         if (!rows[i].wr) chk(rd, rows[i].d);
      end
      // Up counting, period 3 duty 1, both levels
      bus(1, 5'h04, 4'hF, 32'h3);
      bus(1, 5'h08, 4'hF, 32'h1);
      for (int s = 1; s >= 0; s--) begin
         bus(1, 5'h00, 4'hF, 32'h9 | (s << 8));
         wait_trig();
         for (int i = 0; i < 8; i++) begin
            chk(channel_output, ((i % 4) <= 1) ? s : !s);
            chk(compare_unit_trigger, i % 4 == 0);
            @(negedge mclk);
         end
      end
      bus(0, 5'h10, 4'hF, 32'h0);
      chk(rd & 32'h4, 32'h0);
      // Force update restarts the period, level changed just before
      bus(1, 5'h04, 4'hF, 32'h40);
      bus(1, 5'h08, 4'hF, 32'h20);
      for (int s = 1; s >= 0; s--) begin
         bus(1, 5'h00, 4'hF, 32'h1409 | (s << 8));
         bus(0, 5'h10, 4'hF, 32'h0);
         chk(rd & 32'h8, s ? 32'h0 : 32'h8);
         do @(negedge mclk); while (channel_output !== !s);
         bus(1, 5'h0C, 4'hF, 32'h1);
         repeat (2) @(negedge mclk);
         chk(channel_output, s);
         repeat (32) @(negedge mclk);
         chk(channel_output, s);
         @(negedge mclk);
         chk(channel_output, !s);
      end
      // Every nonzero direction mode counts down after the top
      for (int u = 1; u < 4; u++) begin
         bus(1, 5'h00, 4'hF, 32'h9 | (u << 4));
         wait_trig();
         bus(0, 5'h10, 4'hF, 32'h0);
         chk(rd & 32'h4, 32'h4);
      end
      // Only the selected trigger turns the count back up
      for (int x = 0; x < 2; x++) begin
         bus(1, 5'h00, 4'hF, 32'h59 | (x << 7));
         wait_trig();
         pulse(x, !x);
         bus(0, 5'h10, 4'hF, 32'h0);
         chk(rd & 32'h4, 32'h4);
         pulse(!x, x);
         bus(0, 5'h10, 4'hF, 32'h0);
         chk(rd & 32'h4, 32'h0);
      end
      // Freeze in up-down with trigger reset: both outputs keep their level
      bus(1, 5'h00, 4'hF, 32'hDB);
      bus(1, 5'h00, 4'hF, 32'hDA);
      @(negedge mclk);
      held = channel_output;
      pulse(1'b1, 1'b1);
      repeat (8) @(negedge mclk);
      chk(channel_output, held);
      chk(channel_output_alt, !held);
      // Modes other than PWM leave the counter idle
      for (int m = 0; m < 4; m++) begin
         if (m != 2) begin
            bus(1, 5'h00, 4'hF, 32'h1 | (m << 2));
            bus(0, 5'h14, 4'hF, 32'h0);
            cnt_seen = rd;
            repeat (9) @(negedge mclk);
            bus(0, 5'h14, 4'hF, 32'h0);
            chk(rd, cnt_seen);
         end
      end
      // Reset in mid-run restores defaults
      bus(1, 5'h00, 4'hF, 32'h9);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      bus(0, 5'h00, 4'hF, 32'h0);
      chk(rd, 32'h8);
      chk(channel_output, 1'b1);
      end_sim();
   end
endmodule : pwm_timer_channel_output_bench
